// >>> verification/ara_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ara_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bench request, wanted outcome, alert sense
  input wire logic ask,
  input wire logic win,
  input wire logic alert_oe,
  // answer towards the manager
  output logic ara_done,
  output logic ara_won
);
  // the address is only answered while alert is pulled low;
  // won is noise outside done, so nothing may trust it there
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ara_done <= 1'b0;
      ara_won <= 1'b0;
    end
    else
    begin
      ara_done <= ask && alert_oe;
      ara_won <= (ask && alert_oe) ? win : !ara_won;
    end
  end
endmodule
`default_nettype wire

// >>> verification/pflm_chk.sv
`timescale 1ns/1ns
`default_nettype none
module pflm_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // alert and fault pins
  input wire logic ara_done,
  input wire logic ara_won,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic [2:0] shared_fault_out_n_o
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // read word stays put until the host takes it
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  // both halves taken together answer within two edges
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  wr_single_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_cause_a: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  won_release_a: assert property (
    alert_oe && ara_done && ara_won |=> !alert_oe)
    else $error("alert kept after won arbitration");
  lost_keep_a: assert property (
    alert_oe && ara_done && !ara_won |=> alert_oe)
    else $error("alert dropped after lost arbitration");
  // open drain pins never drive high
  open_drain_a: assert property (
    !alert_o && shared_fault_out_n_o == 3'h0)
    else $error("open drain pin driven high");
endmodule

bind power_fault_lock_manager pflm_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .ara_done, .ara_won, .alert_o, .alert_oe,
  .shared_fault_out_n_o
);
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef enum {W, B, R, S, U, V, I, T, A, L, E, F, P, C} op_e;
  localparam logic [31:0] KEY = 32'h0BADF00D; // arbitrary key value
  logic clock, rst_n, ask, win, alert_o, alert_oe, ara_done, ara_won, control_input_n;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, wrsp, rrsp;
  logic [255:0] v_meas, i_meas;
  logic [79:0] t_meas;
  logic [11:0] supply_en;
  logic [2:0] shared_fault_out_n_o, shared_fault_out_n_oe;
  int bad_count, checks;

  // short tick keeps timing checks quick
  power_fault_lock_manager #(.TICK_CYCLES(4), .SERIAL_KEY(KEY)) i_dut (
    .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .v_meas, .i_meas, .t_meas,
    .control_input_n, .ara_done, .ara_won, .supply_en, .alert_o, .alert_oe,
    .shared_fault_out_n_o, .shared_fault_out_n_oe
  );
  ara_host_model i_ara (.clock, .rst_n, .ask, .win, .alert_oe, .ara_done, .ara_won);

  // 250 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // both halves offered at once; each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    wrsp = s_axi_bresp;
    bad_count += (n == 50);
  endtask

  // stall delays rready to make the slave hold its answer
  task automatic rd(input logic [7:0] a, input int stall);
    int n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (n == stall)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    bad_count += (n == 50);
  endtask

  // one scripted step: act, let it settle, then compare
  task automatic st(input op_e op, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m = 32'hFFFFFFFF);
    case (op)
      W, B: wr(a, d);
      R, U: rd(a, 0);
      S: rd(a, 3);
      V: v_meas[a*16 +: 16] <= d[15:0];
      I: i_meas[a*16 +: 16] <= d[15:0];
      T: t_meas[a*16 +: 16] <= d[15:0];
      C: control_input_n <= d[0];
      P: repeat (d) @(posedge clock);
      A:
      begin
        ask <= 1'b1;
        win <= d[0];
        @(posedge clock);
        ask <= 1'b0;
      end
      default: ;
    endcase
    if (op inside {V, I, T, L, E, F, C})
      repeat (8) @(posedge clock);
    case (op)
      B: chk({30'h0, wrsp}, {30'h0, pflm_pkg::RESP_OK});
      R, S: chk(rdat & m, d);
      U: chk({30'h0, rrsp}, d);
      L: chk({31'h0, alert_oe}, d);
      E: chk({31'h0, supply_en[a]}, d);
      F: chk({31'h0, shared_fault_out_n_oe[a]}, d);
      default: ;
    endcase
  endtask

  // hang guard, far beyond the scripted run
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    give_verdict();
  end

  // main script
  initial
  begin
    {ask, win, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, v_meas, i_meas, t_meas} = '0;
    control_input_n = 1'b1;
    rst_n = 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    st(R, pflm_pkg::A_OVL, 32'h7FFF);
    st(U, 8'h48, {30'h0, pflm_pkg::RESP_ERR});
    st(W, pflm_pkg::A_MODE, 32'h1);
    st(W, pflm_pkg::A_FUNC, 32'h10);
    st(W, pflm_pkg::A_OVL, 32'h3E8);
    st(V, 0, 32'h4B0);
    st(R, pflm_pkg::A_CHSTAT, 32'h2);
    st(L, 0, 32'h1);
    st(V, 0, 32'h1F4);
    st(S, pflm_pkg::A_CHSTAT, 32'h2);
    st(V, 0, 32'hF277);
    st(R, pflm_pkg::A_VREAD, 32'hD89);
    st(V, 0, 32'h0);
    st(A, 0, 32'h0);
    st(L, 0, 32'h1);
    st(A, 0, 32'h1);
    st(L, 0, 32'h0);
    st(W, pflm_pkg::A_CLEAR, 32'h0);
    st(R, pflm_pkg::A_CHSTAT, 32'h0);
    st(W, pflm_pkg::A_PAGE, 32'h2);
    st(W, pflm_pkg::A_FUNC, 32'h22);
    st(W, pflm_pkg::A_OCL, 32'h64);
    st(I, 2, 32'hC8);
    st(R, pflm_pkg::A_CHSTAT, 32'h8);
    st(W, pflm_pkg::A_OTL, 32'h1388);
    st(W, pflm_pkg::A_TSEN, 32'h1);
    st(T, 0, 32'h1770);
    st(T, 1, 32'h1770);
    st(R, pflm_pkg::A_VSTAT, 32'h8, 32'h18);
    st(T, 0, 32'h0);
    st(W, pflm_pkg::A_CLEAR, 32'h0);
    st(W, pflm_pkg::A_PAGE, 32'hC);
    st(W, pflm_pkg::A_FUNC, 32'h20);
    st(W, pflm_pkg::A_UVL, 32'h3E8);
    st(W, pflm_pkg::A_PGON, 32'h7D0);
    st(V, 12, 32'h1F4);
    st(R, pflm_pkg::A_CHSTAT, 32'h0);
    st(V, 12, 32'h9C4);
    st(V, 12, 32'h1F4);
    st(R, pflm_pkg::A_CHSTAT, 32'h4);
    st(W, pflm_pkg::A_PAGE, 32'h4);
    st(W, pflm_pkg::A_FUNC, 32'h10);
    st(W, pflm_pkg::A_OVL, 32'h3E8);
    st(W, pflm_pkg::A_REACT, 32'h5);
    st(V, 4, 32'h5DC);
    st(F, 0, 32'h1);
    st(W, pflm_pkg::A_OPER, 32'h80);
    st(E, 4, 32'h0);
    st(V, 4, 32'h0);
    st(W, pflm_pkg::A_CLEAR, 32'h0);
    st(W, pflm_pkg::A_OPER, 32'h0);
    st(W, pflm_pkg::A_OPER, 32'h80);
    st(E, 4, 32'h1);
    st(P, 0, 32'd40);
    st(R, pflm_pkg::A_CHSTAT, 32'h0, 32'h10);
    st(V, 4, 32'h5DC);
    st(E, 4, 32'h0);
    st(V, 4, 32'h0);
    st(W, pflm_pkg::A_CLEAR, 32'h0);
    st(E, 4, 32'h0);
    st(W, pflm_pkg::A_TONMAX, 32'h2);
    st(W, pflm_pkg::A_OPER, 32'h0);
    st(W, pflm_pkg::A_OPER, 32'h80);
    st(P, 0, 32'd40);
    st(R, pflm_pkg::A_CHSTAT, 32'h10, 32'h10);
    st(W, pflm_pkg::A_OPER, 32'h0);
    st(W, pflm_pkg::A_MODE, 32'h4);
    st(C, 0, 32'h0);
    st(E, 0, 32'h1);
    st(C, 0, 32'h1);
    st(E, 0, 32'h0);
    st(W, pflm_pkg::A_MODE, 32'h2);
    st(R, pflm_pkg::A_VSTAT, 32'h1, 32'h1);
    st(R, pflm_pkg::A_OVL, {16'h0, pflm_pkg::LOCKED_READ});
    st(B, pflm_pkg::A_OVL, 32'hC8);
    st(W, pflm_pkg::A_SERIAL, KEY);
    st(R, pflm_pkg::A_VSTAT, 32'h0, 32'h1);
    st(R, pflm_pkg::A_OVL, 32'h3E8);
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> verilog/pflm_pkg.sv
// Functional notes
// - parametric values are 16-bit two's complement
// - voltage counts: 1 mV each, to 32767
// - current counts: 0.01 A each, to 327.67
// - temperature counts: 0.01 C each
// - timing counts: 0.2 ms each, to 6553.4
// - voltages reported positive, two data bytes
// - faults set status; alert if enabled
// - alert response answered, alert released
// - status latched until clear, reset
// - latched-off supply restarts on off-then-on
// - per channel response and fault pins
// - precheck ov, oc, ot before enabling
// - overvoltage watched for function 10h or 20h
// - undervoltage armed after power-good-on reached
// - overcurrent watched for function 22h
// - power-up time checked only while powering, 10h
// - overtemperature watched per enabled sensor
// - locked reads of protected registers give FFFFh
// - locked writes only page, operation, clear, serial
// - lock bit locks; matching serial unlocks
// - lock status always readable
// - arbitration lost keeps alert asserted
// - zero time limit disables power-up check
package pflm_pkg;
  localparam int unsigned NCH = 16;
  localparam int unsigned NSEQ = 12;
  localparam int unsigned NTS = 5;
  // value scaling: counts per unit, coefficient exponent
  localparam int unsigned VOLT_SLOPE = 1;
  localparam int unsigned CURR_EXP = 2;
  localparam int unsigned TEMP_EXP = 2;
  localparam int unsigned TIME_SLOPE = 5;
  // one timing count is 0.2 ms = 200000 ns at 4 ns per cycle
  localparam int unsigned TIME_COUNT_NS = 200000;
  localparam int unsigned CLK_NS = 4;
  localparam int unsigned TICK_CYCLES = TIME_COUNT_NS / CLK_NS;
  // function codes
  localparam logic [5:0] SEL_SEQ_V = 6'h10;
  localparam logic [5:0] SEL_MON_V = 6'h20;
  localparam logic [5:0] SEL_MON_I = 6'h22;
  localparam logic [1:0] RESP_LATCH = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  // register byte offsets
  localparam logic [7:0] A_PAGE = 8'h00;
  localparam logic [7:0] A_OPER = 8'h04;
  localparam logic [7:0] A_CLEAR = 8'h08;
  localparam logic [7:0] A_MODE = 8'h0C;
  localparam logic [7:0] A_FUNC = 8'h10;
  localparam logic [7:0] A_REACT = 8'h14;
  localparam logic [7:0] A_OVL = 8'h18;
  localparam logic [7:0] A_UVL = 8'h1C;
  localparam logic [7:0] A_PGON = 8'h20;
  localparam logic [7:0] A_OCL = 8'h24;
  localparam logic [7:0] A_OTL = 8'h28;
  localparam logic [7:0] A_TONMAX = 8'h2C;
  localparam logic [7:0] A_TSEN = 8'h30;
  localparam logic [7:0] A_SERIAL = 8'h34;
  localparam logic [7:0] A_CHSTAT = 8'h38;
  localparam logic [7:0] A_VSTAT = 8'h3C;
  localparam logic [7:0] A_VREAD = 8'h40;
  localparam logic [7:0] A_RETRY = 8'h44;
  // mode bits
  localparam int unsigned M_ALERT = 0;
  localparam int unsigned M_LOCK = 1;
  localparam int unsigned M_CTL = 2;
  localparam int unsigned OP_ON = 7;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [15:0] LOCKED_READ = 16'hFFFF;
endpackage

// >>> verilog/power_fault_lock_manager.sv
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module power_fault_lock_manager #(
  parameter int unsigned TICK_CYCLES = pflm_pkg::TICK_CYCLES,
  // unlock key, value arbitrary
  parameter logic [31:0] SERIAL_KEY = 32'h5A5A1234
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurements, 16-bit signed per channel or sensor
  input wire logic [255:0] v_meas,
  input wire logic [255:0] i_meas,
  input wire logic [79:0] t_meas,
  // pins and serial engine
  input wire logic control_input_n,
  input wire logic ara_done,
  input wire logic ara_won,
  output logic [11:0] supply_en,
  output logic alert_o,
  output logic alert_oe,
  output logic [2:0] shared_fault_out_n_o,
  output logic [2:0] shared_fault_out_n_oe
);
  localparam int unsigned NCH = pflm_pkg::NCH;
  localparam int unsigned NSEQ = pflm_pkg::NSEQ;
  localparam int unsigned NTS = pflm_pkg::NTS;

  // bus state
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
  logic [7:0] wa_q, wa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  // configuration
  logic [3:0] page_q, page_d;
  logic op_q, op_d, locked_q, locked_d;
  logic [2:0] mode_q, mode_d;
  logic [5:0] sel_q [NCH], sel_d [NCH];
  logic [4:0] react_q [NCH], react_d [NCH];
  logic [15:0] ovl_q [NCH], ovl_d [NCH];
  logic [15:0] uvl_q [NCH], uvl_d [NCH];
  logic [15:0] pgon_q [NCH], pgon_d [NCH];
  logic [15:0] ocl_q [NCH], ocl_d [NCH];
  logic [15:0] tonmax_q [NCH], tonmax_d [NCH];
  logic [15:0] otl_q, otl_d, retry_q, retry_d;
  logic [NTS-1:0] tsen_q, tsen_d;
  // status and control
  logic [NCH-1:0] ovs_q, ovs_d, uvs_q, uvs_d, ocs_q, ocs_d, tons_q, tons_d;
  logic [NTS-1:0] ots_q, ots_d;
  logic [NCH-1:0] latch_q, latch_d, rpend_q, rpend_d, arm_q, arm_d;
  logic [NSEQ-1:0] on_q, on_d;
  logic [15:0] tcnt_q [NSEQ], tcnt_d [NSEQ];
  logic [15:0] rcnt_q, rcnt_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick_q, tick_d;
  logic ctl_s1_q, ctl_s2_q, run_prev_q;
  logic alert_q, alert_d;
  logic [2:0] fpin_q, fpin_d;

  // combinational helpers
  logic [15:0] vmag [NCH];
  logic [NCH-1:0] ov_c, uv_c, oc_c, ton_c, pre_blk, pg_c;
  logic [NTS-1:0] ot_c;
  logic ot_any, run, run_rise, wr_go, rd_go, clr, new_fault;
  logic [7:0] ra;
  logic [31:0] rdata;
  logic rerr, werr, wr_ok;

  // fault conditions per channel
  always_comb
  begin
    for (int s = 0; s < NTS; s++)
    begin
      ot_c[s] = tsen_q[s] && ($signed(t_meas[s*16 +: 16]) > $signed(otl_q));
    end
    ot_any = |ot_c;
    for (int c = 0; c < NCH; c++)
    begin
      // readback and limits are magnitudes in 1 mV counts
      vmag[c] = v_meas[c*16+15] ? 16'(-v_meas[c*16 +: 16]) : v_meas[c*16 +: 16];
      pg_c[c] = vmag[c] > pgon_q[c];
      ov_c[c] = ((sel_q[c] == pflm_pkg::SEL_SEQ_V) || (sel_q[c] == pflm_pkg::SEL_MON_V))
                && (vmag[c] > ovl_q[c]);
      uv_c[c] = ((sel_q[c] == pflm_pkg::SEL_SEQ_V) || (sel_q[c] == pflm_pkg::SEL_MON_V))
                && arm_q[c] && (vmag[c] < uvl_q[c]);
      // current in 0.01 A counts, signed
      oc_c[c] = (sel_q[c] == pflm_pkg::SEL_MON_I)
                && ($signed(i_meas[c*16 +: 16]) > $signed(ocl_q[c]));
      pre_blk[c] = ((react_q[c][1:0] == pflm_pkg::RESP_LATCH)
                    || (react_q[c][1:0] == pflm_pkg::RESP_RETRY))
                   && (ov_c[c] || oc_c[c] || ot_any);
      ton_c[c] = 1'b0;
    end
    for (int c = 0; c < NSEQ; c++)
    begin
      // a zero limit turns the check off; counts are 0.2 ms ticks
      ton_c[c] = (sel_q[c] == pflm_pkg::SEL_SEQ_V) && on_q[c] && !arm_q[c]
                 && (tonmax_q[c] != 16'h0000)
                 && (tcnt_q[c] >= tonmax_q[c]);
    end
  end

  // bus handshake and decode
  always_comb
  begin
    aw_d = aw_q;
    w_d = w_q;
    wa_d = wa_q;
    wd_d = wd_q;
    b_d = b_q;
    br_d = br_q;
    r_d = r_q;
    rr_d = rr_q;
    rd_d = rd_q;
    if (s_axi_awvalid && awr_q)
    begin
      aw_d = 1'b1;
      wa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q)
    begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
    end
    wr_go = aw_q && w_q && !b_q;
    if (wr_go)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      br_d = werr ? pflm_pkg::RESP_ERR : pflm_pkg::RESP_OK;
    end
    else if (b_q && s_axi_bready)
    begin
      b_d = 1'b0;
    end
    rd_go = s_axi_arvalid && arr_q;
    if (rd_go)
    begin
      r_d = 1'b1;
      rd_d = rdata;
      rr_d = rerr ? pflm_pkg::RESP_ERR : pflm_pkg::RESP_OK;
    end
    else if (r_q && s_axi_rready)
    begin
      r_d = 1'b0;
    end
    awr_d = !aw_d && !b_d;
    wr_d = !w_d && !b_d;
    arr_d = !r_d;
  end

  // read mux; protected settings read as FFFFh while locked
  always_comb
  begin
    ra = s_axi_araddr;
    rdata = 32'h00000000;
    rerr = 1'b0;
    unique case (ra)
      pflm_pkg::A_PAGE: rdata[3:0] = page_q;
      pflm_pkg::A_OPER: rdata[pflm_pkg::OP_ON] = op_q;
      pflm_pkg::A_MODE: rdata[2:0] = mode_q;
      pflm_pkg::A_FUNC: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : {10'h000, sel_q[page_q]};
      pflm_pkg::A_REACT: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : {11'h000, react_q[page_q]};
      pflm_pkg::A_OVL: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : ovl_q[page_q];
      pflm_pkg::A_UVL: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : uvl_q[page_q];
      pflm_pkg::A_PGON: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : pgon_q[page_q];
      pflm_pkg::A_OCL: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : ocl_q[page_q];
      pflm_pkg::A_OTL: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : otl_q;
      pflm_pkg::A_TONMAX: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : tonmax_q[page_q];
      pflm_pkg::A_TSEN: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : {11'h000, tsen_q};
      pflm_pkg::A_RETRY: rdata[15:0] = locked_q ? pflm_pkg::LOCKED_READ : retry_q;
      pflm_pkg::A_CHSTAT: rdata[6:0] = {latch_q[page_q], 1'b0, tons_q[page_q], ocs_q[page_q],
                                        uvs_q[page_q], ovs_q[page_q], |ots_q};
      pflm_pkg::A_VSTAT: rdata[7:0] = {ots_q, fpin_q[0], alert_q, locked_q};
      pflm_pkg::A_VREAD: rdata[15:0] = vmag[page_q];
      pflm_pkg::A_CLEAR, pflm_pkg::A_SERIAL: rdata = 32'h00000000;
      default: rerr = 1'b1;
    endcase
    unique case (wa_q)
      pflm_pkg::A_PAGE, pflm_pkg::A_OPER, pflm_pkg::A_CLEAR, pflm_pkg::A_MODE,
      pflm_pkg::A_FUNC, pflm_pkg::A_REACT, pflm_pkg::A_OVL, pflm_pkg::A_UVL,
      pflm_pkg::A_PGON, pflm_pkg::A_OCL, pflm_pkg::A_OTL, pflm_pkg::A_TONMAX,
      pflm_pkg::A_TSEN, pflm_pkg::A_SERIAL, pflm_pkg::A_RETRY: werr = 1'b0;
      default: werr = 1'b1;
    endcase
    // while locked only page, operation, clear and serial land
    wr_ok = wr_go && (!locked_q || (wa_q == pflm_pkg::A_PAGE) || (wa_q == pflm_pkg::A_OPER)
                      || (wa_q == pflm_pkg::A_CLEAR) || (wa_q == pflm_pkg::A_SERIAL));
  end

  // register writes and lock
  always_comb
  begin
    page_d = page_q;
    op_d = op_q;
    mode_d = mode_q;
    locked_d = locked_q;
    otl_d = otl_q;
    retry_d = retry_q;
    tsen_d = tsen_q;
    for (int c = 0; c < NCH; c++)
    begin
      sel_d[c] = sel_q[c];
      react_d[c] = react_q[c];
      ovl_d[c] = ovl_q[c];
      uvl_d[c] = uvl_q[c];
      pgon_d[c] = pgon_q[c];
      ocl_d[c] = ocl_q[c];
      tonmax_d[c] = tonmax_q[c];
    end
    clr = wr_ok && (wa_q == pflm_pkg::A_CLEAR);
    if (wr_ok)
    begin
      unique case (wa_q)
        pflm_pkg::A_PAGE: page_d = wd_q[3:0];
        pflm_pkg::A_OPER: op_d = wd_q[pflm_pkg::OP_ON];
        pflm_pkg::A_MODE:
        begin
          mode_d = wd_q[2:0];
          if (wd_q[pflm_pkg::M_LOCK])
          begin
            locked_d = 1'b1;
          end
        end
        pflm_pkg::A_FUNC: sel_d[page_q] = wd_q[5:0];
        pflm_pkg::A_REACT: react_d[page_q] = wd_q[4:0];
        // limits take exactly the low two bytes; only current and temperature limits are signed counts
        pflm_pkg::A_OVL: ovl_d[page_q] = wd_q[15:0];
        pflm_pkg::A_UVL: uvl_d[page_q] = wd_q[15:0];
        pflm_pkg::A_PGON: pgon_d[page_q] = wd_q[15:0];
        pflm_pkg::A_OCL: ocl_d[page_q] = wd_q[15:0];
        pflm_pkg::A_OTL: otl_d = wd_q[15:0];
        pflm_pkg::A_TONMAX: tonmax_d[page_q] = wd_q[15:0];
        pflm_pkg::A_TSEN: tsen_d = wd_q[NTS-1:0];
        pflm_pkg::A_RETRY: retry_d = wd_q[15:0];
        pflm_pkg::A_SERIAL:
        begin
          if (wd_q == SERIAL_KEY)
          begin
            locked_d = 1'b0;
          end
        end
        default: locked_d = locked_d;
      endcase
    end
  end

  // supervision: status, latch-off, enables, timers, pins, alert
  always_comb
  begin
    // control pin is active low and only steers when enabled
    run = op_q || (mode_q[pflm_pkg::M_CTL] && !ctl_s2_q);
    run_rise = run && !run_prev_q;
    tick_d = 1'b0;
    tick_cnt_d = tick_cnt_q + 32'h00000001;
    if (tick_cnt_q >= 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_d = 32'h00000000;
      tick_d = 1'b1;
    end
    // set wins over clear so no event is lost
    ovs_d = (clr ? '0 : ovs_q) | ov_c;
    uvs_d = (clr ? '0 : uvs_q) | uv_c;
    ocs_d = (clr ? '0 : ocs_q) | oc_c;
    tons_d = (clr ? '0 : tons_q) | ton_c;
    ots_d = (clr ? '0 : ots_q) | ot_c;
    new_fault = |(ov_c & ~ovs_q) || |(uv_c & ~uvs_q) || |(oc_c & ~ocs_q)
                || |(ton_c & ~tons_q) || |(ot_c & ~ots_q);
    latch_d = run_rise ? '0 : latch_q;
    rpend_d = run_rise ? '0 : rpend_q;
    fpin_d = 3'h0;
    rcnt_d = (|rpend_q && tick_q) ? 16'(rcnt_q + 16'h0001) : rcnt_q;
    // retry channels come back after the retry interval
    if (|rpend_q && (rcnt_q >= retry_q))
    begin
      latch_d = latch_d & ~rpend_q;
      rpend_d = '0;
      rcnt_d = 16'h0000;
    end
    for (int c = 0; c < NCH; c++)
    begin
      if (ov_c[c] || uv_c[c] || oc_c[c] || ton_c[c] || ot_any)
      begin
        if ((react_q[c][1:0] == pflm_pkg::RESP_LATCH)
            || (react_q[c][1:0] == pflm_pkg::RESP_RETRY))
        begin
          latch_d[c] = 1'b1;
        end
        if (react_q[c][1:0] == pflm_pkg::RESP_RETRY)
        begin
          rpend_d[c] = 1'b1;
        end
      end
      // pins stay low while the channel's fault is latched or pending
      if ((ovs_q[c] || uvs_q[c] || ocs_q[c] || tons_q[c] || pre_blk[c])
          && (react_q[c][1:0] != 2'h0))
      begin
        fpin_d = fpin_d | react_q[c][4:2];
      end
    end
    for (int c = 0; c < NSEQ; c++)
    begin
      on_d[c] = run && !latch_q[c] && !(pre_blk[c] && !on_q[c]);
      tcnt_d[c] = (on_q[c] && !arm_q[c] && tick_q) ? 16'(tcnt_q[c] + 16'h0001) : tcnt_q[c];
      if (!on_q[c])
      begin
        tcnt_d[c] = 16'h0000;
      end
    end
    for (int c = 0; c < NCH; c++)
    begin
      // sequenced rails arm at power-good while on; pure monitors arm at power-good and stay armed
      if (c < NSEQ)
      begin
        arm_d[c] = on_q[c] && (arm_q[c] || pg_c[c]);
      end
      else
      begin
        arm_d[c] = arm_q[c] || pg_c[c];
      end
    end
    // alert drops when arbitration is won or on clear
    alert_d = alert_q;
    if (ara_done && ara_won)
    begin
      alert_d = 1'b0;
    end
    if (clr)
    begin
      alert_d = 1'b0;
    end
    if (new_fault && mode_q[pflm_pkg::M_ALERT])
    begin
      alert_d = 1'b1;
    end
  end

  // all state registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awr_q <= 1'b0;
      wr_q <= 1'b0;
      arr_q <= 1'b0;
      wa_q <= 8'h00;
      wd_q <= 32'h00000000;
      rd_q <= 32'h00000000;
      br_q <= 2'h0;
      rr_q <= 2'h0;
      page_q <= 4'h0;
      op_q <= 1'b0;
      mode_q <= 3'h0;
      locked_q <= 1'b0;
      otl_q <= 16'h7FFF;
      retry_q <= 16'h0000;
      tsen_q <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        sel_q[c] <= 6'h00;
        react_q[c] <= 5'h00;
        ovl_q[c] <= 16'h7FFF;
        uvl_q[c] <= 16'h0000;
        pgon_q[c] <= 16'h0000;
        ocl_q[c] <= 16'h7FFF;
        tonmax_q[c] <= 16'h0000;
      end
      for (int c = 0; c < NSEQ; c++)
      begin
        tcnt_q[c] <= 16'h0000;
      end
      ovs_q <= '0;
      uvs_q <= '0;
      ocs_q <= '0;
      tons_q <= '0;
      ots_q <= '0;
      latch_q <= '0;
      rpend_q <= '0;
      arm_q <= '0;
      on_q <= '0;
      rcnt_q <= 16'h0000;
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
      ctl_s1_q <= 1'b1;
      ctl_s2_q <= 1'b1;
      run_prev_q <= 1'b0;
      alert_q <= 1'b0;
      fpin_q <= 3'h0;
    end
    else
    begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awr_q <= awr_d;
      wr_q <= wr_d;
      arr_q <= arr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      br_q <= br_d;
      rr_q <= rr_d;
      page_q <= page_d;
      op_q <= op_d;
      mode_q <= mode_d;
      locked_q <= locked_d;
      otl_q <= otl_d;
      retry_q <= retry_d;
      tsen_q <= tsen_d;
      sel_q <= sel_d;
      react_q <= react_d;
      ovl_q <= ovl_d;
      uvl_q <= uvl_d;
      pgon_q <= pgon_d;
      ocl_q <= ocl_d;
      tonmax_q <= tonmax_d;
      tcnt_q <= tcnt_d;
      ovs_q <= ovs_d;
      uvs_q <= uvs_d;
      ocs_q <= ocs_d;
      tons_q <= tons_d;
      ots_q <= ots_d;
      latch_q <= latch_d;
      rpend_q <= rpend_d;
      arm_q <= arm_d;
      on_q <= on_d;
      rcnt_q <= rcnt_d;
      tick_cnt_q <= tick_cnt_d;
      tick_q <= tick_d;
      ctl_s1_q <= control_input_n;
      ctl_s2_q <= ctl_s1_q;
      run_prev_q <= run;
      alert_q <= alert_d;
      fpin_q <= fpin_d;
    end
  end

  // outputs straight from flops, pin data tied low; open-drain drives only low
  assign s_axi_awready = awr_q;
  assign s_axi_wready = wr_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;
  assign supply_en = on_q;
  assign alert_o = 1'b0;
  assign alert_oe = alert_q;
  assign shared_fault_out_n_o = 3'h0;
  assign shared_fault_out_n_oe = fpin_q;
endmodule
`default_nettype wire
